//--- core/iisl_defs.vh
// register offsets, bit positions and reset values of the interrupt status logic
`ifndef IISL_DEFS_VH
`define IISL_DEFS_VH
`define IISL_STAT_OFFSET 32'h5000132C
`define IISL_STAT_WIDTH 16
`define IISL_STAT_RESET 16'h0000
`define IISL_MASK_RESET 16'h08FF
`define IISL_FIFO_DEPTH 6'h20
`define IISL_BIT_RX_UNDER 0
`define IISL_BIT_RX_OVER 1
`define IISL_BIT_RX_FULL 2
`define IISL_BIT_TX_OVER 3
`define IISL_BIT_TX_EMPTY 4
`define IISL_BIT_RD_REQ 5
`define IISL_BIT_TX_ABRT 6
`define IISL_BIT_TX_DONE 7
`define IISL_BIT_ACTIVITY 8
`define IISL_BIT_STOP 9
`define IISL_BIT_START 10
`define IISL_NUM_FLAGS 11
`endif

//--- core/iisl_bus_cond.v
// start and stop condition detector on sampled scl and sda
`timescale 1ns/10ps
module iisl_bus_cond (
    input wire clk_in,      // system clock
    input wire rstn_in,     // async reset, active low
    input wire scl_in,      // sampled serial clock
    input wire sda_in,      // sampled serial data
    output reg start_out,   // one-cycle pulse on start or restart
    output reg stop_out     // one-cycle pulse on stop
);
    reg sda_q;
    // sda edge while scl high marks a bus condition, any role
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sda_q <= 1'b1;
            start_out <= 1'b0;
            stop_out <= 1'b0;
        end else begin
            sda_q <= sda_in;
            start_out <= scl_in & sda_q & ~sda_in;
            stop_out <= scl_in & ~sda_q & sda_in;
        end
    end
endmodule

//--- core/iisl_sticky.v
// bank of sticky flags where a set beats a clear in the same cycle
`timescale 1ns/10ps
module iisl_sticky #(
    parameter N = 4
) (
    input wire clk_in,          // system clock
    input wire rstn_in,         // async reset, active low
    input wire [N-1:0] set_in,  // set pulses
    input wire [N-1:0] clr_in,  // clear pulses
    output reg [N-1:0] flag_out // flag levels
);
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_flag
            // set wins so no event is lost
            always @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    flag_out[i] <= 1'b0;
                end else if (set_in[i]) begin
                    flag_out[i] <= 1'b1;
                end else if (clr_in[i]) begin
                    flag_out[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule

//--- core/iisl_top.v
// interrupt status logic: raw flags, masking and clear-on-read effects
`timescale 1ns/10ps
`include "iisl_defs.vh"
// How it works
// - start or restart sets start flag
// - stop condition sets stop flag
// - activity flag sticky once controller active
// - activity cleared by disable, clear reads, reset
// - master nack as slave transmitter sets done
// - transmit abort sets flag, cause recorded
// - tx fifo flushed until abort clear read
// - slave read request sets flag, stretches clock
// - read request clear read drops flag
// - tx empty while level at/below threshold
// - disabled: tx flushed, empty follows activity
// - write into full tx fifo sets overflow
// - overflow/underflow held until internal enable falls
// - rx full while level at/above threshold
// - disable flushes rx, clears rx full
// - byte into full rx: ack, drop, flag
// - data read on empty rx sets underflow
// - masked status is raw and mask
module iisl_top (
    input wire CLK_IN,                 // 250 MHz system clock
    input wire RSTN_IN,                // async reset, active low
    input wire SCL_IN,                 // serial clock level on the bus
    input wire SDA_IN,                 // serial data level on the bus
    input wire CONTROLLER_ENABLE_BIT_IN, // software enable bit
    input wire MST_ACTIVE_IN,          // master state machine busy
    input wire SLV_ACTIVE_IN,          // slave state machine busy
    input wire SLV_TX_NACK_IN,         // pulse: master nacked our slave byte
    input wire ABORT_IN,               // pulse: transmit abort
    input wire [15:0] ABORT_CAUSE_IN,  // abort reason at the abort pulse
    input wire SLV_RD_ADDR_IN,         // pulse: addressed as slave for read
    input wire TX_WRITE_IN,            // pulse: data_command_port write
    input wire RX_READ_IN,             // pulse: data_command_port read
    input wire RX_BYTE_IN,             // pulse: byte received from bus
    input wire [5:0] TX_LEVEL_IN,      // tx fifo fill level
    input wire [5:0] RX_LEVEL_IN,      // rx fifo fill level
    input wire [5:0] TX_THRESHOLD_IN,  // tx_threshold_reg value
    input wire [5:0] RX_THRESHOLD_LEVEL_IN, // rx_threshold_level value
    input wire [15:0] IRQ_MASK_IN,     // irq_mask_reg value
    input wire RD_ACTIVITY_CLR_IN,     // pulse: activity_clear_reg read
    input wire RD_COMBINED_CLR_IN,     // pulse: combined_irq_clear_reg read
    input wire RD_ABORT_CLR_IN,        // pulse: abort_clear_reg read
    input wire RD_RDREQ_CLR_IN,        // pulse: read_request_clear_reg read
    output reg [15:0] MASKED_IRQ_STATUS_REG_OUT, // masked status register
    output reg [15:0] ABORT_CAUSE_REG_OUT, // abort_cause_reg
    output reg INTERNAL_ENABLE_STATE_OUT,  // internal enable
    output wire TX_FLUSH_OUT,          // hold tx fifo in reset
    output wire RX_FLUSH_OUT,          // hold rx fifo in reset
    output wire RX_DISCARD_OUT,        // ack but drop current byte
    output wire SCL_HOLD_OUT,          // stretch scl low
    output reg IRQ_OUT                 // interrupt request
);
    wire start_p;
    wire stop_p;
    wire busy;
    wire rx_full_lvl;
    wire [6:0] sticky_set;
    wire [6:0] sticky_clr;
    wire [6:0] sticky_q;
    wire tx_empty;
    wire rx_full;
    wire [15:0] raw_status;
    reg busy_q;

    // mask a status word, reused for the register and the request
    function [15:0] iisl_mask;
        input [15:0] raw;
        input [15:0] msk;
        begin
            iisl_mask = raw & msk;
        end
    endfunction

    iisl_bus_cond u_cond (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .scl_in(SCL_IN),
        .sda_in(SDA_IN),
        .start_out(start_p),
        .stop_out(stop_p)
    );

    assign busy = MST_ACTIVE_IN | SLV_ACTIVE_IN;
    assign rx_full_lvl = (RX_LEVEL_IN == `IISL_FIFO_DEPTH);

    // internal enable falls only once both state machines are idle
    always @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            INTERNAL_ENABLE_STATE_OUT <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy;
            if (CONTROLLER_ENABLE_BIT_IN) begin
                INTERNAL_ENABLE_STATE_OUT <= 1'b1;
            end else if (!busy) begin
                INTERNAL_ENABLE_STATE_OUT <= 1'b0;
            end
        end
    end

    // sticky event sets; index order: under, over_rx, over_tx, rdreq, abrt, done, act
    assign sticky_set[0] = RX_READ_IN & (RX_LEVEL_IN == 6'h00);
    assign sticky_set[1] = RX_BYTE_IN & rx_full_lvl;
    assign sticky_set[2] = TX_WRITE_IN & (TX_LEVEL_IN == `IISL_FIFO_DEPTH);
    assign sticky_set[3] = SLV_RD_ADDR_IN;
    assign sticky_set[4] = ABORT_IN;
    assign sticky_set[5] = SLV_TX_NACK_IN;
    assign sticky_set[6] = busy & ~busy_q & CONTROLLER_ENABLE_BIT_IN;

    // clear sources; combined clear read drops every sticky flag
    assign sticky_clr[0] = RD_COMBINED_CLR_IN | ~INTERNAL_ENABLE_STATE_OUT;
    assign sticky_clr[1] = RD_COMBINED_CLR_IN | ~INTERNAL_ENABLE_STATE_OUT;
    assign sticky_clr[2] = RD_COMBINED_CLR_IN | ~INTERNAL_ENABLE_STATE_OUT;
    assign sticky_clr[3] = RD_RDREQ_CLR_IN | RD_COMBINED_CLR_IN | ~CONTROLLER_ENABLE_BIT_IN;
    assign sticky_clr[4] = RD_ABORT_CLR_IN | RD_COMBINED_CLR_IN | ~CONTROLLER_ENABLE_BIT_IN;
    assign sticky_clr[5] = RD_COMBINED_CLR_IN | ~CONTROLLER_ENABLE_BIT_IN;
    assign sticky_clr[6] = RD_ACTIVITY_CLR_IN | RD_COMBINED_CLR_IN | ~CONTROLLER_ENABLE_BIT_IN;

    iisl_sticky #(
        .N(7)
    ) u_sticky (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .set_in(sticky_set),
        .clr_in(sticky_clr),
        .flag_out(sticky_q)
    );

    // start and stop flags share the bank style but live here for clarity
    reg start_q;
    reg stop_q;
    always @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            start_q <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            if (start_p) begin
                start_q <= 1'b1;
            end else if (RD_COMBINED_CLR_IN | ~CONTROLLER_ENABLE_BIT_IN) begin
                start_q <= 1'b0;
            end
            if (stop_p) begin
                stop_q <= 1'b1;
            end else if (RD_COMBINED_CLR_IN | ~CONTROLLER_ENABLE_BIT_IN) begin
                stop_q <= 1'b0;
            end
        end
    end

    // abort cause captured with the abort, dropped on its clear
    always @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ABORT_CAUSE_REG_OUT <= 16'h0000;
        end else if (ABORT_IN) begin
            ABORT_CAUSE_REG_OUT <= ABORT_CAUSE_IN;
        end else if (RD_ABORT_CLR_IN | RD_COMBINED_CLR_IN) begin
            ABORT_CAUSE_REG_OUT <= 16'h0000;
        end
    end

    // level flags follow the fifo levels while enabled, tx empty follows busy when disabled; no storage needed
    assign tx_empty = CONTROLLER_ENABLE_BIT_IN ?
        (TX_LEVEL_IN <= TX_THRESHOLD_IN) : busy;
    assign rx_full = CONTROLLER_ENABLE_BIT_IN &
        (RX_LEVEL_IN >= RX_THRESHOLD_LEVEL_IN);

    // fifo control: abort keeps tx flushed until its clear read
    assign TX_FLUSH_OUT = sticky_q[4] | ~CONTROLLER_ENABLE_BIT_IN;
    assign RX_FLUSH_OUT = ~CONTROLLER_ENABLE_BIT_IN;
    assign RX_DISCARD_OUT = RX_BYTE_IN & rx_full_lvl;
    // stretch lasts until the clear read retires the request, so the host must
    // load its byte before that read or the remote master clocks stale data
    assign SCL_HOLD_OUT = sticky_q[3];

    assign raw_status = {5'h00, start_q, stop_q, sticky_q[6], sticky_q[5], sticky_q[4],
        sticky_q[3], tx_empty, sticky_q[2], rx_full, sticky_q[1], sticky_q[0]};

    // outputs registered so the status read is glitch free, one cycle late
    always @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            MASKED_IRQ_STATUS_REG_OUT <= `IISL_STAT_RESET;
            IRQ_OUT <= 1'b0;
        end else begin
            MASKED_IRQ_STATUS_REG_OUT <= iisl_mask(raw_status, IRQ_MASK_IN);
            IRQ_OUT <= |iisl_mask(raw_status, IRQ_MASK_IN);
        end
    end
endmodule

//--- testbench/iisl_chk.sv
// port-level assertions for the interrupt status logic
`timescale 1ns/10ps
module iisl_chk (
    input wire logic CLK_IN, // system clock
    input wire logic RSTN_IN, // async reset, active low
    input wire logic SCL_IN, // bus clock level
    input wire logic SDA_IN, // bus data level
    input wire logic CONTROLLER_ENABLE_BIT_IN, // software enable
    input wire logic ABORT_IN, // abort pulse
    input wire logic SLV_RD_ADDR_IN, // slave read address pulse
    input wire logic RX_BYTE_IN, // received byte pulse
    input wire logic RD_COMBINED_CLR_IN, // combined clear read
    input wire logic RD_ABORT_CLR_IN, // abort clear read
    input wire logic RD_RDREQ_CLR_IN, // read request clear read
    input wire logic TX_FLUSH_OUT, // tx fifo held in reset
    input wire logic RX_DISCARD_OUT, // received byte dropped
    input wire logic SCL_HOLD_OUT, // clock stretch
    input wire logic IRQ_OUT, // interrupt request
    input wire logic [15:0] ABORT_CAUSE_IN, // abort reason
    input wire logic [15:0] IRQ_MASK_IN, // status mask
    input wire logic [15:0] MASKED_IRQ_STATUS_REG_OUT, // masked status
    input wire logic [15:0] ABORT_CAUSE_REG_OUT, // captured abort reason
    input wire logic [5:0] TX_LEVEL_IN, // tx fill level
    input wire logic [5:0] RX_LEVEL_IN, // rx fill level
    input wire logic [5:0] TX_THRESHOLD_IN // tx threshold
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    // short aliases keep each property to at most three lines
    wire [15:0] st = MASKED_IRQ_STATUS_REG_OUT;
    wire [15:0] m = IRQ_MASK_IN;
    wire en = CONTROLLER_ENABLE_BIT_IN;
    wire ncl = !RD_COMBINED_CLR_IN;
    // detector adds one stage, so the status bit lands three edges later; the check waits four
    start_flag_a: assert property (($fell(SDA_IN) && SCL_IN && $past(SCL_IN) && m[10])
        ##1 (en && ncl && m[10])[*3] |=> st[10]) else $error("start not flagged");
    stop_flag_a: assert property (($rose(SDA_IN) && SCL_IN && $past(SCL_IN) && m[9])
        ##1 (en && ncl && m[9])[*3] |=> st[9]) else $error("stop not flagged");
    abort_flag_a: assert property ((ABORT_IN && m[6])
        ##1 (en && ncl && !RD_ABORT_CLR_IN && m[6]) |=> st[6]) else $error("abort not flagged");
    abort_cause_a: assert property (ABORT_IN |=> ABORT_CAUSE_REG_OUT == $past(ABORT_CAUSE_IN))
        else $error("abort cause not kept");
    tx_flush_a: assert property (ABORT_IN |=> TX_FLUSH_OUT) else $error("tx not flushed");
    rd_hold_a: assert property (SLV_RD_ADDR_IN |=> SCL_HOLD_OUT) else $error("scl not held");
    rd_clear_a: assert property ((RD_RDREQ_CLR_IN && !SLV_RD_ADDR_IN) ##1 !SLV_RD_ADDR_IN
        |=> !st[5]) else $error("read request not cleared");
    tx_empty_a: assert property ((en && m[4] && $stable(TX_LEVEL_IN)
        && $stable(TX_THRESHOLD_IN))[*3] |-> st[4] == (TX_LEVEL_IN <= TX_THRESHOLD_IN))
        else $error("tx empty wrong");
    rx_off_a: assert property (!en [*2] |-> !st[2]) else $error("rx full while disabled");
    rx_drop_a: assert property (en && RX_BYTE_IN && RX_LEVEL_IN == 6'h20 |-> RX_DISCARD_OUT)
        else $error("byte into full rx kept");
    irq_or_a: assert property (IRQ_OUT == (|st)) else $error("irq not or of status");
    cover property (ABORT_IN ##1 TX_FLUSH_OUT);
    cover property (SLV_RD_ADDR_IN ##1 SCL_HOLD_OUT);
    cover property (!en && st[3]);
endmodule
bind iisl_top iisl_chk u_chk (.*);

//--- testbench/iisl_bus_model.sv
// remote bus party that makes start and stop conditions
`timescale 1ns/10ps
module iisl_bus_model (
    input wire logic clk_in, // pacing clock
    output logic scl_out,    // serial clock, pulled high when idle
    output logic sda_out     // serial data, pulled high when idle
);
    // idle bus sits at the pull-up level
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task step;
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    // data falls while the clock is high
    task start_cond;
        sda_out = 1'b0;
        step();
        scl_out = 1'b0;
        step();
    endtask
    // clock rises first so the data rise is a stop, not a data bit
    task stop_cond;
        scl_out = 1'b1;
        step();
        sda_out = 1'b1;
        step();
    endtask
endmodule

//--- testbench/test_iisl_top.sv
// self-checking bench for the interrupt status logic
`timescale 1ns/10ps
module test_iisl_top;
    logic clk = 0, rstn = 0, en = 1, mst = 0, slv = 0, nack = 0, abrt = 0, rdad = 0;
    logic txw = 0, rxr = 0, rxb = 0, rdac = 0, rdcc = 0, rdab = 0, rdrq = 0;
    logic [15:0] cause = 16'h0000, mask = 16'h07FF;
    logic [5:0] txl = 6'h05, rxl = 6'h03, txt = 6'h02, rxt = 6'h04;
    wire [15:0] st, acause;
    wire ien, txf, rxf, disc, hold, irq, scl, sda;
    int miscompares = 0, n_compared = 0;
    always #2 clk = ~clk;
    iisl_bus_model u_bus (.clk_in(clk), .scl_out(scl), .sda_out(sda));
    iisl_top u_dut (.CLK_IN(clk), .RSTN_IN(rstn), .SCL_IN(scl), .SDA_IN(sda),
        .CONTROLLER_ENABLE_BIT_IN(en), .MST_ACTIVE_IN(mst), .SLV_ACTIVE_IN(slv),
        .SLV_TX_NACK_IN(nack), .ABORT_IN(abrt), .ABORT_CAUSE_IN(cause), .SLV_RD_ADDR_IN(rdad),
        .TX_WRITE_IN(txw), .RX_READ_IN(rxr), .RX_BYTE_IN(rxb), .TX_LEVEL_IN(txl),
        .RX_LEVEL_IN(rxl), .TX_THRESHOLD_IN(txt), .RX_THRESHOLD_LEVEL_IN(rxt),
        .IRQ_MASK_IN(mask), .RD_ACTIVITY_CLR_IN(rdac), .RD_COMBINED_CLR_IN(rdcc),
        .RD_ABORT_CLR_IN(rdab), .RD_RDREQ_CLR_IN(rdrq), .MASKED_IRQ_STATUS_REG_OUT(st),
        .ABORT_CAUSE_REG_OUT(acause), .INTERNAL_ENABLE_STATE_OUT(ien), .TX_FLUSH_OUT(txf),
        .RX_FLUSH_OUT(rxf), .RX_DISCARD_OUT(disc), .SCL_HOLD_OUT(hold), .IRQ_OUT(irq));
    // inputs always move 1 ns after the rising edge
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // four edges cover the worst status lag of a sticky flag
    task st_is(input logic [15:0] exp);
        tick(4);
        chk(st, exp);
    endtask
    task close_out;
        $display("compared %0d, unexpected %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // cut a hang short
    initial begin
        #100000;
        miscompares++;
        close_out();
    end
    initial begin
        tick(12);
        rstn = 1'b1;
        st_is(16'h0000);
        u_bus.start_cond();
        st_is(16'h0400);
        u_bus.stop_cond();
        st_is(16'h0600);
        chk(16'(irq), 16'h0001);
        pulse(rdcc);
        st_is(16'h0000);
        pulse(mst);
        st_is(16'h0100);
        pulse(rdac);
        st_is(16'h0000);
        pulse(slv);
        st_is(16'h0100);
        en = 1'b0;
        st_is(16'h0000);
        en = 1'b1;
        cause = 16'h00A5;
        pulse(abrt);
        st_is(16'h0040);
        chk(acause, 16'h00A5);
        chk(16'(txf), 16'h0001);
        pulse(rdab);
        st_is(16'h0000);
        chk(16'(txf), 16'h0000);
        pulse(rdad);
        st_is(16'h0020);
        chk(16'(hold), 16'h0001);
        pulse(txw);
        pulse(rdrq);
        st_is(16'h0000);
        chk(16'(hold), 16'h0000);
        pulse(nack);
        st_is(16'h0080);
        pulse(rdcc);
        txl = 6'h20;
        pulse(txw);
        rxl = 6'h00;
        pulse(rxr);
        rxl = 6'h20;
        rxb = 1'b1;
        #1 chk(16'(disc), 16'h0001);
        tick(1);
        rxb = 1'b0;
        st_is(16'h000F);
        mst = 1'b1;
        en = 1'b0;
        st_is(16'h001B);
        chk(16'(rxf), 16'h0001);
        chk(16'(ien), 16'h0001);
        chk(16'(txf), 16'h0001);
        mst = 1'b0;
        st_is(16'h0000);
        chk(16'(ien), 16'h0000);
        en = 1'b1;
        txl = 6'h02;
        rxl = 6'h04;
        st_is(16'h0014);
        chk(16'(rxf), 16'h0000);
        txl = 6'h03;
        rxl = 6'h03;
        st_is(16'h0000);
        txl = 6'h02;
        mask = 16'h07EF;
        st_is(16'h0000);
        chk(16'(irq), 16'h0000);
        // mid-run reset must drop a standing activity flag
        pulse(mst);
        st_is(16'h0100);
        rstn = 1'b0;
        tick(2);
        rstn = 1'b1;
        st_is(16'h0000);
        chk(16'(ien), 16'h0001);
        close_out();
    end
endmodule
